// ---- inc/wkcs_consts.svh ----
`ifndef WKCS_CONSTS_SVH
`define WKCS_CONSTS_SVH

// Register byte offsets
`define WKCS_OFS_FILTER    12'h128
`define WKCS_OFS_WCS       12'h12C
`define WKCS_OFS_ADDR_LO   12'h200
`define WKCS_OFS_ADDR_HI   12'h204
`define WKCS_OFS_CTRL      12'h208
`define WKCS_OFS_IRQ_STS   12'h20C
`define WKCS_OFS_IRQ_MASK  12'h210

// Control and status bit positions
`define WKCS_BIT_REWIND    31
`define WKCS_BIT_GU_EN     9
`define WKCS_BIT_ADDR_RX   7
`define WKCS_BIT_PAT_RX    6
`define WKCS_BIT_MAGIC_RX  5
`define WKCS_BIT_BCAST_RX  4
`define WKCS_BIT_ADDR_EN   3
`define WKCS_BIT_PAT_EN    2
`define WKCS_BIT_MAGIC_EN  1
`define WKCS_BIT_BROADCAST_WAKE_ENABLE  0
`define WKCS_BIT_RES_CLR   0
`define WKCS_BIT_IRQ_WAKE  4

// Reset values
`define WKCS_RST_WORD      32'h0000_0000
`define WKCS_RST_FLAGS     4'h0
`define WKCS_RST_IRQ       5'h00

// Pattern filter depth in words
`define WKCS_FILTER_DEPTH  6'h28
`define WKCS_FILTER_LAST   6'h27

`endif

// ---- inc/wkcs_pkg.sv ----
package wkcs_pkg;
  typedef logic [31:0] wkcs_word_t;
  typedef logic [5:0]  wkcs_ptr_t;
  typedef logic [11:0] wkcs_addr_t;
  typedef enum logic [1:0] {
    WKCS_OKAY   = 2'h0,
    WKCS_SLVERR = 2'h2
  } wkcs_resp_t;
endpackage

// ---- logic/wkcs_filter_ptr.sv ----
`timescale 1ns/1ps
`include "wkcs_consts.svh"
module wkcs_filter_ptr
  import wkcs_pkg::*;
(
  input  wire logic      aclk,
  input  wire logic      aresetn,
  input  wire logic      rewind,
  input  wire logic      advance,
  output wkcs_ptr_t      ptr
);

  wkcs_ptr_t ptr_q;
  wkcs_ptr_t ptr_d;

  // Rewind beats a same-cycle advance
  always_comb begin
    ptr_d = ptr_q;
    if (rewind) begin
      ptr_d = 6'h00;
    end else if (advance) begin
      ptr_d = (ptr_q == `WKCS_FILTER_LAST) ? 6'h00 : ptr_q + 6'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_q <= 6'h00;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  assign ptr = ptr_q;

  ptr_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ptr_q == `WKCS_FILTER_LAST && advance && !rewind |=> ptr_q == 6'h00)
    else $error("filter pointer did not wrap after last entry");

  ptr_rewind_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rewind |=> ptr_q == 6'h00)
    else $error("filter pointer not rewound");

endmodule // wkcs_filter_ptr

// ---- logic/wkcs_axil_slave.sv ----
`timescale 1ns/1ps
module wkcs_axil_slave
  import wkcs_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire wkcs_addr_t s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire wkcs_word_t s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire wkcs_addr_t s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output wkcs_word_t      s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  output logic            wr_en,
  output wkcs_addr_t      wr_addr,
  output wkcs_word_t      wr_data,
  output logic [3:0]      wr_strb,
  input  wire logic       wr_ok,
  output logic            rd_en,
  output wkcs_addr_t      rd_addr,
  input  wire wkcs_word_t rd_data,
  input  wire logic       rd_ok
);

  logic aw_have_q;
  logic w_have_q;

  // Address and data may come in either order; hold each until both
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign wr_en         = aw_have_q && w_have_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      wr_addr   <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      wr_addr   <= {s_axi_awaddr[11:2], 2'b00};
    end else if (wr_en) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wr_data  <= 32'h0000_0000;
      wr_strb  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wr_data  <= s_axi_wdata;
      wr_strb  <= s_axi_wstrb;
    end else if (wr_en) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= WKCS_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? WKCS_OKAY : WKCS_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read side effects fire on the accepting edge, so one read per request
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_en         = s_axi_arvalid && s_axi_arready;
  assign rd_addr       = {s_axi_araddr[11:2], 2'b00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= WKCS_OKAY;
    end else if (rd_en) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_ok ? WKCS_OKAY : WKCS_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  bresp_timing_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en |=> s_axi_bvalid ##0 !s_axi_awready)
    else $error("write response not raised after write");

  rvalid_timing_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_en |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not raised after read accept");

endmodule // wkcs_axil_slave

// ---- logic/wkcs_top.sv ----
// Operation
// - Writing one to bit 31 rewinds both filter pointers; bit reads zero
// - Global unicast enable at bit 9 wakes on a global unicast frame
// - A frame is global unicast when destination bit 0 is zero
// - Global unicast wake also needs the pattern wake enable at bit 2
// - Address match flag at bit 7 sets on own-address frame
// - Pattern frame flag at bit 6 sets on filter match
// - Magic frame flag at bit 5 sets on valid magic packet
// - Broadcast flag at bit 4 sets on valid broadcast frame
// - With resume option set, finished resume clears all four flags
// - Address match enable at bit 3 arms wake on own-address frame
// - Own address comes from station address high and low registers
// - Pattern enable at bit 2 arms wake on programmed filter match
// - Magic enable at bit 1 arms wake on magic packet
// - Broadcast enable at bit 0 arms wake on broadcast frame
// - Filter port accesses step through 40 words, wrapping to first
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "wkcs_consts.svh"
module wkcs_top
  import wkcs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire wkcs_addr_t  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire wkcs_word_t  s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire wkcs_addr_t  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output wkcs_word_t       s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rx_frame_valid,
  input  wire logic [47:0] rx_dest_addr,
  input  wire logic        rx_magic_packet,
  input  wire logic        rx_pattern_match,
  input  wire logic        resume_done,
  output logic             wake_request,
  output logic             irq
);

  logic       wr_en;
  wkcs_addr_t wr_addr;
  wkcs_word_t wr_data;
  logic [3:0] wr_strb;
  logic       wr_ok;
  logic       rd_en;
  wkcs_addr_t rd_addr;
  wkcs_word_t rd_data;
  logic       rd_ok;

  wkcs_axil_slave u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_ok         (wr_ok),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  function automatic wkcs_word_t merge(input wkcs_word_t old_v,
                                       input wkcs_word_t new_v,
                                       input logic [3:0] strb);
    wkcs_word_t res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Register select
  logic wr_filter;
  logic wr_wcs;
  logic wr_lo;
  logic wr_hi;
  logic wr_ctrl;
  logic wr_ists;
  logic wr_imask;
  logic rd_filter;

  assign wr_filter = wr_en && wr_addr == `WKCS_OFS_FILTER;
  assign wr_wcs    = wr_en && wr_addr == `WKCS_OFS_WCS;
  assign wr_lo     = wr_en && wr_addr == `WKCS_OFS_ADDR_LO;
  assign wr_hi     = wr_en && wr_addr == `WKCS_OFS_ADDR_HI;
  assign wr_ctrl   = wr_en && wr_addr == `WKCS_OFS_CTRL;
  assign wr_ists   = wr_en && wr_addr == `WKCS_OFS_IRQ_STS;
  assign wr_imask  = wr_en && wr_addr == `WKCS_OFS_IRQ_MASK;
  assign rd_filter = rd_en && rd_addr == `WKCS_OFS_FILTER;
  assign wr_ok     = wr_filter || wr_wcs || wr_lo || wr_hi || wr_ctrl ||
                     wr_ists || wr_imask;

  // Enables {address, pattern, magic, broadcast} at bits 3:0
  logic [3:0] wake_en_q;
  logic       gu_en_q;
  logic       res_clr_q;
  wkcs_word_t addr_lo_q;
  wkcs_word_t addr_hi_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_en_q <= `WKCS_RST_FLAGS;
      gu_en_q   <= 1'b0;
    end else if (wr_wcs) begin
      if (wr_strb[0]) begin
        wake_en_q <= wr_data[`WKCS_BIT_ADDR_EN:`WKCS_BIT_BROADCAST_WAKE_ENABLE];
      end
      if (wr_strb[1]) begin
        gu_en_q <= wr_data[`WKCS_BIT_GU_EN];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_lo_q <= `WKCS_RST_WORD;
      addr_hi_q <= `WKCS_RST_WORD;
      res_clr_q <= 1'b0;
    end else begin
      if (wr_lo) begin
        addr_lo_q <= merge(addr_lo_q, wr_data, wr_strb);
      end
      if (wr_hi) begin
        addr_hi_q <= merge(addr_hi_q, wr_data, wr_strb) & 32'h0000_FFFF;
      end
      if (wr_ctrl && wr_strb[0]) begin
        res_clr_q <= wr_data[`WKCS_BIT_RES_CLR];
      end
    end
  end

  // Pattern filter port: separate read and write walkers
  logic      rewind;
  wkcs_ptr_t wr_ptr;
  wkcs_ptr_t rd_ptr;

  assign rewind = wr_wcs && wr_strb[3] && wr_data[`WKCS_BIT_REWIND];

  wkcs_filter_ptr u_wr_ptr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rewind  (rewind),
    .advance (wr_filter),
    .ptr     (wr_ptr)
  );

  wkcs_filter_ptr u_rd_ptr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rewind  (rewind),
    .advance (rd_filter),
    .ptr     (rd_ptr)
  );

  wkcs_word_t filter_q [`WKCS_FILTER_DEPTH];

  generate
    for (genvar i = 0; i < `WKCS_FILTER_DEPTH; i++) begin : g_filter
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          filter_q[i] <= `WKCS_RST_WORD;
        end else if (wr_filter && wr_ptr == 6'(i)) begin
          filter_q[i] <= merge(filter_q[i], wr_data, wr_strb);
        end
      end
    end
  endgenerate

  // Frame classification
  logic       addr_hit;
  logic       bcast_hit;
  logic       gu_hit;
  logic [3:0] rx_ev;
  logic       wake_d;

  assign addr_hit  = rx_dest_addr == {addr_hi_q[15:0], addr_lo_q};
  assign bcast_hit = &rx_dest_addr;
  assign gu_hit    = !rx_dest_addr[0];
  assign rx_ev     = {4{rx_frame_valid}} &
                     {addr_hit, rx_pattern_match, rx_magic_packet, bcast_hit};
  assign wake_d    = |(rx_ev & wake_en_q) ||
                     (rx_frame_valid && gu_hit && gu_en_q &&
                      wake_en_q[`WKCS_BIT_PAT_EN]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= wake_d;
    end
  end

  // Received flags {address, pattern, magic, broadcast}; a new frame
  // outweighs a clear in the same cycle so no event is lost
  logic [3:0] rx_flags_q;
  logic [3:0] rx_clr;

  assign rx_clr = ({4{wr_wcs && wr_strb[0]}} &
                   wr_data[`WKCS_BIT_ADDR_RX:`WKCS_BIT_BCAST_RX]) |
                  {4{resume_done && res_clr_q}};

  generate
    for (genvar f = 0; f < 4; f++) begin : g_flag
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          rx_flags_q[f] <= 1'b0;
        end else if (rx_ev[f]) begin
          rx_flags_q[f] <= 1'b1;
        end else if (rx_clr[f]) begin
          rx_flags_q[f] <= 1'b0;
        end
      end
    end
  endgenerate

  // Interrupt status: received events plus wake, same layout as mask
  logic [4:0] irq_sts_q;
  logic [4:0] irq_mask_q;
  logic [4:0] irq_ev;

  assign irq_ev = {wake_d, rx_ev};

  generate
    for (genvar k = 0; k < 5; k++) begin : g_irq
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          irq_sts_q[k] <= 1'b0;
        end else if (irq_ev[k]) begin
          irq_sts_q[k] <= 1'b1;
        end else if (wr_ists && wr_strb[0] && wr_data[k]) begin
          irq_sts_q[k] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_q <= `WKCS_RST_IRQ;
    end else if (wr_imask && wr_strb[0]) begin
      irq_mask_q <= wr_data[4:0];
    end
  end

  assign irq = |(irq_sts_q & irq_mask_q);

  // Read mux; rewind and reserved bits read zero
  always_comb begin
    rd_data = `WKCS_RST_WORD;
    rd_ok   = 1'b1;
    unique case (rd_addr)
      `WKCS_OFS_FILTER:   rd_data = filter_q[rd_ptr];
      `WKCS_OFS_WCS: begin
        rd_data[`WKCS_BIT_GU_EN] = gu_en_q;
        rd_data[`WKCS_BIT_ADDR_RX:`WKCS_BIT_BCAST_RX] = rx_flags_q;
        rd_data[`WKCS_BIT_ADDR_EN:`WKCS_BIT_BROADCAST_WAKE_ENABLE] = wake_en_q;
      end
      `WKCS_OFS_ADDR_LO:  rd_data = addr_lo_q;
      `WKCS_OFS_ADDR_HI:  rd_data = addr_hi_q;
      `WKCS_OFS_CTRL:     rd_data[`WKCS_BIT_RES_CLR] = res_clr_q;
      `WKCS_OFS_IRQ_STS:  rd_data[4:0] = irq_sts_q;
      `WKCS_OFS_IRQ_MASK: rd_data[4:0] = irq_mask_q;
      default:            rd_ok = 1'b0;
    endcase
  end

  gu_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_frame_valid && !rx_dest_addr[0] && gu_en_q &&
    wake_en_q[`WKCS_BIT_PAT_EN] |=> wake_request)
    else $error("global unicast frame did not wake");

  gu_needs_pattern_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    rx_frame_valid && wake_en_q == 4'h0 |=> !wake_request)
    else $error("wake without pattern enable");

  addr_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_frame_valid && rx_dest_addr == {addr_hi_q[15:0], addr_lo_q}
    |=> rx_flags_q[3])
    else $error("address match flag not set");

  pattern_flag_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    rx_frame_valid && rx_pattern_match |=> rx_flags_q[2])
    else $error("pattern flag not set");

  magic_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_frame_valid && rx_magic_packet |=> rx_flags_q[1])
    else $error("magic flag not set");

  bcast_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_frame_valid && rx_dest_addr == 48'hFFFF_FFFF_FFFF |=> rx_flags_q[0])
    else $error("broadcast flag not set");

  resume_clear_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    resume_done && res_clr_q && !rx_frame_valid |=> rx_flags_q == 4'h0)
    else $error("resume did not clear flags");

  flag_w1c_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_wcs && wr_strb[0] && !rx_frame_valid && !resume_done
    |=> rx_flags_q == ($past(rx_flags_q) & ~$past(wr_data[7:4])))
    else $error("flag write-one-clear wrong");

  reset_zero_a: assert property (@(posedge aclk)
    !aresetn |=> wake_en_q == 4'h0 && !gu_en_q && rx_flags_q == 4'h0)
    else $error("enables or flags not zero after reset");

  bcast_wake_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    rx_frame_valid && &rx_dest_addr && wake_en_q[0] |=> wake_request)
    else $error("armed broadcast did not wake");

endmodule // wkcs_top

// ---- verif/wkcs_rx_model.sv ----
`timescale 1ns/1ps
module wkcs_rx_model (
  input  wire logic   aclk,
  output logic        rx_frame_valid,
  output logic [47:0] rx_dest_addr,
  output logic        rx_magic_packet,
  output logic        rx_pattern_match,
  output logic        resume_done
);
  initial begin
    rx_frame_valid   = 1'b0;
    rx_dest_addr     = 48'h0000_0000_0000;
    rx_magic_packet  = 1'b0;
    rx_pattern_match = 1'b0;
    resume_done      = 1'b0;
  end

  // Idle qualifiers flip so a stale frame can never look valid
  task automatic frame(input logic [47:0] d, input logic mg, input logic pt);
    rx_frame_valid   <= 1'b1;
    rx_dest_addr     <= d;
    rx_magic_packet  <= mg;
    rx_pattern_match <= pt;
    @(posedge aclk);
    rx_frame_valid   <= 1'b0;
    rx_dest_addr     <= ~d;
    rx_magic_packet  <= ~mg;
    rx_pattern_match <= ~pt;
  endtask

  task automatic resume();
    resume_done <= 1'b1;
    @(posedge aclk);
    resume_done <= 1'b0;
  endtask
endmodule // wkcs_rx_model

// ---- verif/wakeup_control_status_tb_top.sv ----
`timescale 1ns/1ps
`include "wkcs_consts.svh"
module wakeup_control_status_tb_top
  import wkcs_pkg::*;
;
  localparam logic [47:0] STA = 48'habcd_1234_5678;
  localparam logic [47:0] MC  = 48'h0100_5e00_0001;
  localparam logic [47:0] BC  = 48'hffff_ffff_ffff;
  localparam logic [47:0] UNI = 48'h0000_0000_0002;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, rx_frame_valid;
  logic        rx_magic_packet, rx_pattern_match, resume_done;
  logic        wake_request, irq, mg, pt;
  wkcs_addr_t  awaddr, araddr;
  wkcs_word_t  wdata, rdata, rd, en, flg;
  logic [1:0]  bresp, rresp, rsp;
  logic [3:0]  wstrb;
  logic [47:0] rx_dest_addr, dst;
  int          fails, check_count;

  wkcs_top dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_frame_valid(rx_frame_valid), .rx_dest_addr(rx_dest_addr),
    .rx_magic_packet(rx_magic_packet), .rx_pattern_match(rx_pattern_match),
    .resume_done(resume_done), .wake_request(wake_request), .irq(irq)
  );

  wkcs_rx_model rx (
    .aclk(aclk), .rx_frame_valid(rx_frame_valid),
    .rx_dest_addr(rx_dest_addr), .rx_magic_packet(rx_magic_packet),
    .rx_pattern_match(rx_pattern_match), .resume_done(resume_done)
  );

  always #2 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input wkcs_addr_t a, input wkcs_word_t d);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    if (n >= 100) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, bvalid, 1'b1);
    end
    rsp = bresp;
  endtask

  task automatic rdc(input wkcs_addr_t a, input wkcs_word_t exp);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    if (n >= 100) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, rvalid, 1'b1);
    end
    rd = rdata;
    rsp = rresp;
    chk(rd, exp);
  endtask

  // Pulse must show the cycle after the frame and be gone one cycle later
  task automatic fire(input logic [47:0] d, input logic m, input logic p,
                      input logic w);
    rx.frame(d, m, p);
    #1;
    chk({31'h0, wake_request}, {31'h0, w});
    @(posedge aclk);
    #1;
    chk({31'h0, wake_request}, 32'h0000_0000);
    // Back on an edge so the next bus call drives at the clock
    @(posedge aclk);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    $display("[ERR] %0t got %h exp %h", $time, 1'b0, 1'b1);
    end_of_test();
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    fails = 0;
    check_count = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({31'h0, irq}, 32'h0000_0000);
    rdc(`WKCS_OFS_WCS, 32'h0000_0000);
    rdc(`WKCS_OFS_IRQ_STS, 32'h0000_0000);
    wr(`WKCS_OFS_ADDR_LO, 32'h1234_5678);
    wr(`WKCS_OFS_ADDR_HI, 32'hffff_abcd);
    rdc(`WKCS_OFS_ADDR_HI, 32'h0000_abcd);
    for (int i = 0; i < 4; i++) begin
      dst = (i == 0) ? STA : (i == 3) ? BC : MC;
      mg = (i == 2);
      pt = (i == 1);
      en = 32'h0000_0008 >> i;
      flg = 32'h0000_0080 >> i;
      wr(`WKCS_OFS_IRQ_MASK, 32'h0000_0000);
      wr(`WKCS_OFS_WCS, 32'h0000_0000);
      fire(dst, mg, pt, 1'b0);
      chk({31'h0, irq}, 32'h0000_0000);
      rdc(`WKCS_OFS_WCS, flg);
      wr(`WKCS_OFS_IRQ_MASK, 32'h0000_001f);
      rdc(`WKCS_OFS_IRQ_STS, en);
      chk({31'h0, irq}, 32'h0000_0001);
      wr(`WKCS_OFS_WCS, en);
      fire(dst, mg, pt, 1'b1);
      rdc(`WKCS_OFS_WCS, flg | en);
      rdc(`WKCS_OFS_IRQ_STS, en | 32'h0000_0010);
      wr(`WKCS_OFS_WCS, flg | en);
      rdc(`WKCS_OFS_WCS, en);
      wr(`WKCS_OFS_IRQ_STS, 32'h0000_001f);
      chk({31'h0, irq}, 32'h0000_0000);
    end
    wr(`WKCS_OFS_WCS, 32'hffff_ff0f);
    rdc(`WKCS_OFS_WCS, 32'h0000_020f);
    wr(`WKCS_OFS_WCS, 32'h0000_0200);
    fire(UNI, 1'b0, 1'b0, 1'b0);
    wr(`WKCS_OFS_WCS, 32'h0000_0204);
    fire(UNI, 1'b0, 1'b0, 1'b1);
    fire(MC, 1'b0, 1'b0, 1'b0);
    rdc(`WKCS_OFS_WCS, 32'h0000_0204);
    wr(`WKCS_OFS_WCS, 32'h0000_0000);
    fire(BC, 1'b0, 1'b0, 1'b0);
    wr(`WKCS_OFS_WCS, 32'h0000_0000);
    rdc(`WKCS_OFS_WCS, 32'h0000_0010);
    rx.resume();
    rdc(`WKCS_OFS_WCS, 32'h0000_0010);
    wr(`WKCS_OFS_CTRL, 32'h0000_0001);
    rx.resume();
    rdc(`WKCS_OFS_WCS, 32'h0000_0000);
    for (int i = 0; i < 40; i++) begin
      wr(`WKCS_OFS_FILTER, i + 1);
    end
    wr(`WKCS_OFS_FILTER, 32'h0000_00aa);
    for (int i = 0; i < 40; i++) begin
      rdc(`WKCS_OFS_FILTER, (i == 0) ? 32'h0000_00aa : i + 1);
    end
    rdc(`WKCS_OFS_FILTER, 32'h0000_00aa);
    rdc(`WKCS_OFS_FILTER, 32'h0000_0002);
    wr(`WKCS_OFS_WCS, 32'h8000_0000);
    rdc(`WKCS_OFS_FILTER, 32'h0000_00aa);
    wr(`WKCS_OFS_FILTER, 32'h0000_0055);
    wr(`WKCS_OFS_WCS, 32'h8000_0000);
    rdc(`WKCS_OFS_FILTER, 32'h0000_0055);
    rdc(`WKCS_OFS_WCS, 32'h0000_0000);
    // Lane 0 only: enables land, unicast enable and rewind must not
    wstrb <= 4'h1;
    wr(`WKCS_OFS_WCS, 32'h8000_0204);
    wstrb <= 4'hf;
    rdc(`WKCS_OFS_WCS, 32'h0000_0004);
    rdc(`WKCS_OFS_FILTER, 32'h0000_0002);
    rdc(12'h300, 32'h0000_0000);
    chk({30'h0, rsp}, 32'h0000_0002);
    wr(12'h300, 32'hffff_ffff);
    chk({30'h0, rsp}, 32'h0000_0002);
    end_of_test();
  end
endmodule // wakeup_control_status_tb_top
